// >>> sim/palette_host_access_port_tb.sv
`timescale 1ns/1ns
module palette_host_access_port_tb;
    import pha_pkg::*;

    logic clk, sys_rst, eightBitMode, hostWrite, hostRead;
    logic [2:0] registerSelect;
    logic [7:0] hostWrData, hostRdData, pixelIndex;
    logic [3:0] overlaySel;
    logic [COMP_W-1:0] pixelRed, pixelGreen, pixelBlue;
    logic [7:0] expQ[$];
    logic [23:0] pal[256];
    logic [23:0] ovl[16];
    logic [23:0] c0, c1, c2;
    int badCount, nCompared, cycles;

    pha_palette_port u_dut (.clk(clk), .sys_rst(sys_rst),
        .registerSelect(registerSelect), .hostWrite(hostWrite),
        .hostRead(hostRead), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .eightBitMode(eightBitMode),
        .pixelIndex(pixelIndex), .overlaySel(overlaySel),
        .pixelRed(pixelRed), .pixelGreen(pixelGreen),
        .pixelBlue(pixelBlue));

    pha_host_model u_host (.clk(clk), .registerSelect(registerSelect),
        .hostWrite(hostWrite), .hostRead(hostRead),
        .hostWrData(hostWrData));

    // 125 MHz clock
    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            badCount++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic giveVerdict();
        if (expQ.size() != 0)
            badCount++;
        $display("Compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // A hang is cut short well beyond the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            giveVerdict();
        end
    end

    // Each read strobe taken is answered one edge later by the oldest note
    always @(posedge clk) begin
        if (hostRead === 1'b1) begin
            @(negedge clk);
            check(hostRdData, expQ.size() ? expQ.pop_front() : 8'hXX);
        end
    end

    task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
        expQ.push_back(exp);
        u_host.access(sel, 1'b0, 8'h00);
    endtask

    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        u_host.access(sel, 1'b1, d);
    endtask

    // Store a triple and note what the entry should now hold
    task automatic put(input logic ov, input logic ld, input logic [7:0] idx,
        input logic [23:0] c);
        logic [7:0] m;
        m = eightBitMode ? 8'hFF : SIX_BIT_MASK;
        u_host.triple(ov ? SEL_IDX_OVL_WR : SEL_IDX_PAL_WR,
            ov ? SEL_OVL_DATA : SEL_PAL_DATA, ld, idx, c);
        if (ov)
            ovl[idx[3:0]] = c & {3{m}};
        else
            pal[idx] = c & {3{m}};
    endtask

    // Read one triple; ld loads the index in read mode first
    task automatic get(input logic ov, input logic ld, input logic [7:0] idx);
        logic [7:0] m;
        logic [23:0] e;
        m = eightBitMode ? 8'hFF : SIX_BIT_MASK;
        e = ov ? ovl[idx[3:0]] : pal[idx];
        if (ld) begin
            wr(ov ? SEL_IDX_OVL_RD : SEL_IDX_PAL_RD, idx);
            u_host.idle(1);
        end
        for (int k = 2; k >= 0; k--)
            rd(ov ? SEL_OVL_DATA : SEL_PAL_DATA, e[k*8 +: 8] & m);
        u_host.idle(1);
    endtask

    // Steady pixel inputs, then compare the converter data
    task automatic pix(input logic [7:0] pi, input logic [3:0] os,
        input logic [23:0] c);
        @(posedge clk);
        pixelIndex <= pi;
        overlaySel <= os;
        repeat (4) @(posedge clk);
        @(negedge clk);
        if (!eightBitMode)
            c = {c[21:16], 2'h0, c[13:8], 2'h0, c[5:0], 2'h0};
        check(pixelRed, c[23:16]);
        check(pixelGreen, c[15:8]);
        check(pixelBlue, c[7:0]);
    endtask

    initial begin
        void'($urandom(32'h7007));
        sys_rst = 1'b1;
        eightBitMode = 1'b1;
        pixelIndex = 8'h00;
        overlaySel = 4'h0;
        badCount = 0;
        nCompared = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values, reserved code reads zero
        rd(SEL_IDX_PAL_WR, INDEX_RESET);
        rd(SEL_READ_MASK, MASK_RESET);
        rd(SEL_RESERVED, 8'h00);
        // Fill the last two entries; the index wraps to the first
        c0 = 24'($urandom);
        c1 = 24'($urandom);
        c2 = 24'($urandom);
        put(1'b0, 1'b1, 8'hFE, c0);
        put(1'b0, 1'b0, 8'hFF, c1);
        rd(SEL_IDX_PAL_RD, 8'h00);
        rd(SEL_IDX_PAL_WR, 8'h00);
        // Reserved write must leave index and phase alone
        wr(SEL_RESERVED, 8'h55);
        rd(SEL_IDX_PAL_WR, 8'h00);
        put(1'b0, 1'b0, 8'h00, c2);
        // Continuous read-back across the wrap
        get(1'b0, 1'b1, 8'hFE);
        get(1'b0, 1'b0, 8'hFF);
        get(1'b0, 1'b0, 8'h00);
        rd(SEL_IDX_PAL_RD, 8'h02);
        // Index write drops a partial triple; index read keeps the phase
        c0 = 24'($urandom);
        c1 = 24'($urandom);
        wr(SEL_IDX_PAL_WR, 8'h10);
        wr(SEL_PAL_DATA, 8'hAA);
        put(1'b0, 1'b1, 8'h10, c0);
        wr(SEL_IDX_PAL_WR, 8'h20);
        wr(SEL_PAL_DATA, c1[23:16]);
        rd(SEL_IDX_PAL_WR, 8'h20);
        wr(SEL_PAL_DATA, c1[15:8]);
        wr(SEL_PAL_DATA, c1[7:0]);
        pal[8'h20] = c1;
        get(1'b0, 1'b1, 8'h10);
        get(1'b0, 1'b1, 8'h20);
        // Read mask gates the pixel index
        wr(SEL_READ_MASK, 8'hF0);
        rd(SEL_READ_MASK, 8'hF0);
        pix(8'h1F, 4'h0, pal[8'h10]);
        // Green output stays put while the host fetches other entries
        fork
            get(1'b0, 1'b1, 8'h20);
            repeat (14) begin
                @(negedge clk);
                check(pixelGreen, pal[8'h10][15:8]);
            end
        join
        // Overlay: upper index nibble ignored, index still advances
        c2 = 24'($urandom);
        put(1'b1, 1'b1, 8'hA3, c2);
        get(1'b1, 1'b1, 8'h03);
        rd(SEL_IDX_OVL_RD, 8'h05);
        pix(8'h00, 4'h3, ovl[3]);
        // Six-bit components: top lines ignored, read back as zero
        @(posedge clk);
        eightBitMode <= 1'b0;
        c0 = 24'($urandom) | 24'hC0C0C0;
        put(1'b0, 1'b1, 8'h30, c0);
        get(1'b0, 1'b1, 8'h30);
        wr(SEL_READ_MASK, 8'hFF);
        pix(8'h30, 4'h0, pal[8'h30]);
        u_host.idle(4);
        giveVerdict();
    end
endmodule

// >>> sim/pha_host_model.sv
`timescale 1ns/1ns
// Bus master beside the palette port: one strobe per access
module pha_host_model
    import pha_pkg::*;
(
    input wire logic clk,
    output logic [2:0] registerSelect,
    output logic hostWrite,
    output logic hostRead,
    output logic [7:0] hostWrData
);
    import pha_pkg::*;

    logic [7:0] lastData;

    // Idle bus at time zero
    initial begin
        registerSelect = SEL_IDX_PAL_WR;
        hostWrite = 1'b0;
        hostRead = 1'b0;
        hostWrData = 8'h00;
        lastData = 8'h00;
    end

    // Strobe raised after an edge, held until the edge that takes it
    task automatic access(input logic [2:0] sel, input logic wr,
        input logic [7:0] data);
        @(posedge clk);
        registerSelect <= sel;
        hostWrite <= wr;
        hostRead <= ~wr;
        hostWrData <= wr ? data : ~lastData;
        if (wr)
            lastData = data;
        @(posedge clk);
        hostWrite <= 1'b0;
        hostRead <= 1'b0;
        // Released lines never keep the last byte, so stale use shows up
        hostWrData <= ~lastData;
    endtask

    // Quiet cycles, e.g. the gap that a table fetch needs
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Index first when ld is set, then red, green and blue, one whole word per triple
    task automatic triple(input logic [2:0] idxSel, input logic [2:0] dSel,
        input logic ld, input logic [7:0] idx, input logic [23:0] c);
        if (ld)
            access(idxSel, 1'b1, idx);
        for (int k = 2; k >= 0; k--)
            access(dSel, 1'b1, c[k*8 +: 8]);
    endtask
endmodule

// >>> verilog/pha_palette_port.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Code 000 selects index, palette write; code 011 index, palette read.
// - 001 palette data, 010 read mask, 100/111 overlay index, 101 data.
// - One 8-bit index addresses both palette and overlay entries.
// - Index, then red, green, blue writes; blue stores the joined word.
// - Index advances by one after each completed write triple.
// - Index load in read mode copies entry to holding, then advances.
// - Reads give red, green, blue; after blue, fetch next and advance.
// - Blue access at last palette location wraps index to zero.
// - Overlay accesses advance index but use only its low four bits.
// - Every table transfer is synchronised to the pixel clock.
// - Table to holding transfer takes one cycle between host accesses.
// - Pixel output keeps the previous colour during host transfers.
// - Phase counts modulo three; index write clears, index read keeps.
// - Phase bits are hidden; only eight index bits are visible.
// - Index bit zero is the least significant address bit.
// - Reading the index changes neither index, phase nor mode.
// - 256 palette entries and fifteen overlay colours.
// - Colour component width selectable as six or eight bits.
// - Phase codes: red 00, green 01, blue 10.
// - Six-bit mode: top data bits ignored on writes, zero on reads.
module pha_palette_port
    import pha_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] registerSelect,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostWrData,
    output logic [7:0] hostRdData,
    input wire logic eightBitMode,
    input wire logic [7:0] pixelIndex,
    input wire logic [3:0] overlaySel,
    output logic [pha_pkg::COMP_W-1:0] pixelRed,
    output logic [pha_pkg::COMP_W-1:0] pixelGreen,
    output logic [pha_pkg::COMP_W-1:0] pixelBlue
);
    import pha_pkg::*;

    typedef enum {PHA_PAL_WR, PHA_PAL_RD, PHA_OVL_WR, PHA_OVL_RD}
        pha_mode_t;

    pha_mode_t mode;
    pha_ram_if ramBus();
    logic [7:0] colourIndex;
    logic [1:0] colourPhase;
    logic [7:0] readMask;
    logic [7:0] redHold;
    logic [7:0] greenHold;
    logic [WORD_W-1:0] rgbHold;
    logic [WORD_W-1:0] overlay [1:OVL_LAST];
    logic [WORD_W-1:0] ovlPick;
    logic [WORD_W-1:0] ovlHostWord;
    logic fetchPal;
    logic fetchOvl;
    logic [WORD_W-1:0] ovlFetchWord;
    logic xferCapture;
    logic xferFromOvl;
    logic idxWr;
    logic idxRd;
    logic dataWr;
    logic dataRd;
    logic blueStep;
    logic fetchNow;
    logic [7:0] fetchAddr;
    logic [7:0] wrComp;
    logic [7:0] next_index;

    // Which select codes reach the index register
    function automatic logic isIndexSel(input logic [2:0] s);
        isIndexSel = (s == SEL_IDX_PAL_WR) || (s == SEL_IDX_PAL_RD) ||
            (s == SEL_IDX_OVL_WR) || (s == SEL_IDX_OVL_RD);
    endfunction

    // Which select codes reach a colour data port
    function automatic logic isDataSel(input logic [2:0] s);
        isDataSel = (s == SEL_PAL_DATA) || (s == SEL_OVL_DATA);
    endfunction

    // Component byte of a word for a given phase
    function automatic logic [7:0] compOf(input logic [23:0] w,
        input logic [1:0] p);
        case (p)
            PHASE_RED: compOf = w[RED_POS +: 8];
            PHASE_GREEN: compOf = w[GREEN_POS +: 8];
            default: compOf = w[BLUE_POS +: 8];
        endcase
    endfunction

    // Strobe decode; the reserved code matches none of these
    assign idxWr = hostWrite && isIndexSel(registerSelect);
    assign idxRd = hostRead && isIndexSel(registerSelect);
    assign dataWr = hostWrite && isDataSel(registerSelect);
    assign dataRd = hostRead && isDataSel(registerSelect);
    assign blueStep = (dataWr || dataRd) && colourPhase == PHASE_BLUE;
    // Six-bit mode drops the top two data lines on writes
    assign wrComp = eightBitMode ? hostWrData
        : (hostWrData & SIX_BIT_MASK);

    // Fetches: on an index load in read mode, or after a blue read
    assign fetchNow = (idxWr && (registerSelect == SEL_IDX_PAL_RD ||
        registerSelect == SEL_IDX_OVL_RD)) || (dataRd && blueStep);
    assign fetchAddr = idxWr ? hostWrData : colourIndex;
    assign fetchPal = fetchNow && (idxWr ?
        registerSelect == SEL_IDX_PAL_RD : registerSelect == SEL_PAL_DATA);
    assign fetchOvl = fetchNow && !fetchPal;

    // Next index: load, or advance after blue; 8-bit wrap is natural
    always_comb begin
        next_index = colourIndex;
        if (idxWr) begin
            next_index = fetchNow ? hostWrData + 8'h01 : hostWrData;
        end else if (blueStep) begin
            next_index = colourIndex + 8'h01;
        end
    end

    // Index register, loaded through select codes 000/011/100/111 and advanced by blue data cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            colourIndex <= INDEX_RESET;
        end else begin
            colourIndex <= next_index;
        end
    end

    // Hidden phase counter: cleared by index write, not by index read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            colourPhase <= PHASE_RED;
        end else if (idxWr) begin
            colourPhase <= PHASE_RED;
        end else if (dataWr || dataRd) begin
            colourPhase <= blueStep ? PHASE_RED
                : colourPhase + 2'h1;
        end
    end

    // Access mode follows the select code of the last index write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= PHA_PAL_WR;
        end else if (idxWr) begin
            case (registerSelect)
                SEL_IDX_PAL_WR: mode <= PHA_PAL_WR;
                SEL_IDX_PAL_RD: mode <= PHA_PAL_RD;
                SEL_IDX_OVL_WR: mode <= PHA_OVL_WR;
                default: mode <= PHA_OVL_RD;
            endcase
        end
    end

    // Pixel read mask, reachable at any time
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readMask <= MASK_RESET;
        end else if (hostWrite && registerSelect == SEL_READ_MASK) begin
            readMask <= hostWrData;
        end
    end

    // Red and green wait here until blue completes the word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            redHold <= 8'h00;
            greenHold <= 8'h00;
        end else if (dataWr) begin
            if (colourPhase == PHASE_RED) begin
                redHold <= wrComp;
            end
            if (colourPhase == PHASE_GREEN) begin
                greenHold <= wrComp;
            end
        end
    end

    // Overlay colours 1..15; colour 0 slot is reserved and not stored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 1; i <= OVL_LAST; i++) begin
                overlay[i] <= 24'h000000;
            end
        end else if (dataWr && blueStep &&
            registerSelect == SEL_OVL_DATA &&
            colourIndex[3:0] != 4'h0) begin
            overlay[colourIndex[3:0]] <= {redHold, greenHold, wrComp};
        end
    end

    // Palette write of the joined word on the blue cycle
    assign ramBus.wrEn = dataWr && blueStep &&
        registerSelect == SEL_PAL_DATA;
    assign ramBus.wrWord = {redHold, greenHold, wrComp};
    assign ramBus.hostAddr = ramBus.wrEn ? colourIndex : fetchAddr;
    assign ramBus.pixAddr = pixelIndex & readMask;

    // Overlay lookups for the pixel path and the host fetch
    assign ovlPick = (overlaySel == 4'h0) ? 24'h000000
        : overlay[overlaySel];
    assign ovlHostWord = (fetchAddr[3:0] == 4'h0) ? 24'h000000
        : overlay[fetchAddr[3:0]];

    // Transfer is issued on the access edge and lands one clock later
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            xferCapture <= 1'b0;
            xferFromOvl <= 1'b0;
            ovlFetchWord <= 24'h000000;
        end else begin
            xferCapture <= fetchNow;
            xferFromOvl <= fetchOvl;
            ovlFetchWord <= ovlHostWord;
        end
    end

    // Holding registers load in the single transfer cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rgbHold <= 24'h000000;
        end else if (xferCapture) begin
            rgbHold <= xferFromOvl ? ovlFetchWord : ramBus.hostWord;
        end
    end

    // Host read data; phase bits are never presented
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hostRdData <= 8'h00;
        end else if (hostRead) begin
            case (registerSelect)
                SEL_IDX_PAL_WR, SEL_IDX_PAL_RD,
                SEL_IDX_OVL_WR, SEL_IDX_OVL_RD: begin
                    hostRdData <= colourIndex;
                end
                SEL_PAL_DATA, SEL_OVL_DATA: begin
                    hostRdData <= eightBitMode ? compOf(rgbHold, colourPhase)
                        : compOf(rgbHold, colourPhase)
                        & SIX_BIT_MASK;
                end
                SEL_READ_MASK: begin
                    hostRdData <= readMask;
                end
                default: begin
                    hostRdData <= 8'h00;
                end
            endcase
        end
    end

    pha_palette_ram ramInst (
        .clk(clk),
        .ram(ramBus.mem)
    );

    // Pixel colour is frozen in the transfer cycle to avoid sparkle
    pha_pixel_stage pixInst (
        .clk(clk),
        .sys_rst(sys_rst),
        .overlaySel(overlaySel),
        .ramWord(ramBus.pixWord),
        .ovlWord(ovlPick),
        .eightBitMode(eightBitMode),
        .holdColour(xferCapture),
        .pixelRed(pixelRed),
        .pixelGreen(pixelGreen),
        .pixelBlue(pixelBlue)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence blueData;
        (dataWr || dataRd) && colourPhase == PHASE_BLUE && !idxWr;
    endsequence

    chk_idx_wr_phase: assert property (
        idxWr |=> colourPhase == PHASE_RED)
        else $error("index write did not clear phase");
    chk_idx_rd_keep: assert property (
        idxRd && !hostWrite |=> $stable(colourIndex) &&
        $stable(colourPhase) && $stable(mode))
        else $error("index read disturbed state");
    chk_blue_adv: assert property (
        blueData |=> colourIndex == $past(colourIndex) + 8'h01)
        else $error("index did not advance after blue");
    chk_wrap_last: assert property (
        blueData ##0 colourIndex == INDEX_LAST |=> colourIndex == 8'h00)
        else $error("index did not wrap");
    chk_rd_load: assert property (
        idxWr && registerSelect == SEL_IDX_PAL_RD |=> xferCapture &&
        colourIndex == $past(hostWrData) + 8'h01 ##1
        xferCapture == $past(fetchNow))
        else $error("read-mode load did not fetch and advance");
    chk_xfer_one: assert property (
        xferCapture && !fetchNow |=> !xferCapture)
        else $error("transfer lasted more than one cycle");
    chk_reserved_zero: assert property (
        hostRead && registerSelect == SEL_RESERVED |=> hostRdData == 8'h00)
        else $error("reserved code read not zero");
    chk_six_bit_rd: assert property (
        dataRd && !eightBitMode |=> hostRdData[7:6] == 2'h0)
        else $error("six-bit read drove top bits");
    chk_phase_range: assert property (
        colourPhase != 2'h3)
        else $error("phase counter left modulo three");

    // Data cycles that no index write overrides in the same clock
    sequence dataCycle;
        (dataWr || dataRd) && !idxWr;
    endsequence

    // Phase walks red, green, blue; no other step is legal
    chk_phase_r2g: assert property (
        dataCycle ##0 colourPhase == PHASE_RED |=>
        colourPhase == PHASE_GREEN)
        else $error("phase did not step from red to green");
    chk_phase_g2b: assert property (
        dataCycle ##0 colourPhase == PHASE_GREEN |=>
        colourPhase == PHASE_BLUE)
        else $error("phase did not step from green to blue");
    // Only the blue cycle may move the index
    chk_rg_keep_idx: assert property (
        dataCycle ##0 colourPhase != PHASE_BLUE |=> $stable(colourIndex))
        else $error("index moved before the blue cycle");

    // Write-mode loads take the host byte as it stands
    chk_idx_load: assert property (
        idxWr && (registerSelect == SEL_IDX_PAL_WR ||
        registerSelect == SEL_IDX_OVL_WR) |=>
        colourIndex == $past(hostWrData))
        else $error("write-mode index load lost the host byte");
    // Overlay read-mode loads must fetch from the overlay bank
    chk_ovl_rd_load: assert property (
        idxWr && registerSelect == SEL_IDX_OVL_RD |=>
        xferCapture && xferFromOvl)
        else $error("overlay read-mode load did not fetch");
    // A blue read queues the next fetch for the gap cycle
    chk_blue_fetch: assert property (
        blueData ##0 dataRd |=> xferCapture)
        else $error("blue read did not fetch the next entry");

    // Host readback of index, write of the read mask; the reserved code is inert
    chk_idx_rd_data: assert property (
        idxRd |=> hostRdData == $past(colourIndex))
        else $error("index read returned a wrong value");
    chk_mask_write: assert property (
        hostWrite && registerSelect == SEL_READ_MASK |=>
        readMask == $past(hostWrData))
        else $error("read mask write lost");
    chk_reserved_keep: assert property (
        hostWrite && registerSelect == SEL_RESERVED |=>
        $stable(colourIndex) && $stable(colourPhase) && $stable(readMask))
        else $error("reserved write changed state");
    // Six-bit writes drop the top two lines before they are held
    chk_wr_six_bit: assert property (
        dataWr && !eightBitMode && colourPhase == PHASE_RED |=>
        redHold[7:6] == 2'h0)
        else $error("six-bit write kept the top data lines");
endmodule

// >>> verilog/pha_palette_ram.sv
`timescale 1ns/1ns
// Colour store with one host port and one pixel read port
module pha_palette_ram
    import pha_pkg::*;
(
    input wire logic clk,
    pha_ram_if.mem ram
);
    logic [WORD_W-1:0] store [0:ENTRIES-1];

    // Read first, read data is the old word; both reads registered
    always_ff @(posedge clk) begin
        if (ram.wrEn) begin
            store[ram.hostAddr] <= ram.wrWord;
        end
        ram.hostWord <= store[ram.hostAddr];
        ram.pixWord <= store[ram.pixAddr];
    end
endmodule

// >>> verilog/pha_pixel_stage.sv
`timescale 1ns/1ns
// Pixel output stage: palette or overlay colour, held during transfers
module pha_pixel_stage
    import pha_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] overlaySel,
    input wire logic [WORD_W-1:0] ramWord,
    input wire logic [WORD_W-1:0] ovlWord,
    input wire logic eightBitMode,
    input wire logic holdColour,
    output logic [COMP_W-1:0] pixelRed,
    output logic [COMP_W-1:0] pixelGreen,
    output logic [COMP_W-1:0] pixelBlue
);
    logic [3:0] ovlSelDly;
    logic [WORD_W-1:0] ovlDly;
    logic [WORD_W-1:0] chosen;

    // Scale a stored component for the converter
    function automatic logic [7:0] toDac(input logic [7:0] c,
        input logic wide);
        toDac = wide ? c : {c[5:0], 2'h0};
    endfunction

    // Overlay choice delayed to line up with the registered palette read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovlSelDly <= 4'h0;
            ovlDly <= 24'h000000;
        end else begin
            ovlSelDly <= overlaySel;
            ovlDly <= ovlWord;
        end
    end

    assign chosen = (ovlSelDly != 4'h0) ? ovlDly : ramWord;

    // Old colour kept while a host transfer touches the table
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pixelRed <= 8'h00;
            pixelGreen <= 8'h00;
            pixelBlue <= 8'h00;
        end else if (!holdColour) begin
            pixelRed <= toDac(chosen[RED_POS +: 8], eightBitMode);
            pixelGreen <= toDac(chosen[GREEN_POS +: 8], eightBitMode);
            pixelBlue <= toDac(chosen[BLUE_POS +: 8], eightBitMode);
        end
    end

    chk_hold_spark: assert property (@(posedge clk) disable iff (sys_rst)
        holdColour |=> $stable(pixelRed) && $stable(pixelGreen) &&
        $stable(pixelBlue))
        else $error("pixel colour changed during transfer");
endmodule

// >>> verilog/pha_pkg.sv
package pha_pkg;
    // Host register-select codes
    localparam logic [2:0] SEL_IDX_PAL_WR = 3'h0;
    localparam logic [2:0] SEL_PAL_DATA = 3'h1;
    localparam logic [2:0] SEL_READ_MASK = 3'h2;
    localparam logic [2:0] SEL_IDX_PAL_RD = 3'h3;
    localparam logic [2:0] SEL_IDX_OVL_WR = 3'h4;
    localparam logic [2:0] SEL_OVL_DATA = 3'h5;
    localparam logic [2:0] SEL_RESERVED = 3'h6;
    localparam logic [2:0] SEL_IDX_OVL_RD = 3'h7;
    // Colour phase codes
    localparam logic [1:0] PHASE_RED = 2'h0;
    localparam logic [1:0] PHASE_GREEN = 2'h1;
    localparam logic [1:0] PHASE_BLUE = 2'h2;
    // Sizes
    localparam int COMP_W = 8;
    localparam int WORD_W = 24;
    localparam int ENTRIES = 256;
    localparam int OVL_LAST = 15;
    // Reset values and masks
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [7:0] SIX_BIT_MASK = 8'h3F;
    localparam logic [7:0] INDEX_LAST = 8'hFF;
    // Red in the top byte, blue in the bottom byte
    localparam int RED_POS = 16;
    localparam int GREEN_POS = 8;
    localparam int BLUE_POS = 0;
endpackage

// >>> verilog/pha_ram_if.sv
`timescale 1ns/1ns
// Palette store ports: host side and pixel side
interface pha_ram_if;
    logic wrEn;
    logic [7:0] hostAddr;
    logic [23:0] wrWord;
    logic [23:0] hostWord;
    logic [7:0] pixAddr;
    logic [23:0] pixWord;
    modport ctrl (output wrEn, output hostAddr, output wrWord,
        output pixAddr, input hostWord, input pixWord);
    modport mem (input wrEn, input hostAddr, input wrWord,
        input pixAddr, output hostWord, output pixWord);
endinterface
